// *** hw/cnts_irq_ctrl.v ***
// Sticky interrupt pending flags, enables and the shared request line
module cnts_irq_ctrl (
    input wire clk,
    input wire reset,
    input wire [15:0] evt,
    input wire en_we,
    input wire clr_we,
    input wire [15:0] wdata,
    output reg [15:0] en_ff,
    output reg [15:0] pend_ff,
    output reg irq_ff
);
    wire [15:0] nxt_pend;
    // Cleared only via clear register; set wins
    assign nxt_pend = (pend_ff & ~(clr_we ? wdata : 16'h0000)) | evt;

    always @(posedge clk) begin
        if (reset) begin
            en_ff <= 16'h0000;
            pend_ff <= 16'h0000;
            irq_ff <= 1'b0;
        end else begin
            if (en_we) begin
                en_ff <= wdata;
            end
            pend_ff <= nxt_pend;
            irq_ff <= |(nxt_pend & (en_we ? wdata : en_ff));
        end
    end
endmodule // cnts_irq_ctrl

// *** hw/cnts_rank_sel.v ***
// Picks the candidate buffer with the smallest combined rank
module cnts_rank_sel #(
    parameter NB = 15
) (
    input wire [NB-1:0] cand,
    input wire [4*NB-1:0] rank,
    output reg found,
    output reg [3:0] idx,
    output reg [7:0] best
);
    // ==========================================================
    // Combined rank per buffer
    wire [8*NB-1:0] crank;
    genvar g;
    generate
        for (g = 0; g < NB; g = g + 1) begin : g_rank
            localparam [3:0] GI = g;
            assign crank[8*g+:8] = {rank[4*g+:4], GI};
        end
    endgenerate

    // ==========================================================
    // Minimum search
    integer i;
    always @* begin
        found = 1'b0;
        idx = 4'h0;
        best = 8'hFF;
        for (i = 0; i < NB; i = i + 1) begin
            if (cand[i] && (!found || crank[8*i+:8] < best)) begin
                found = 1'b1;
                idx = crank[8*i+:4];
                best = crank[8*i+:8];
            end
        end
    end
endmodule // cnts_rank_sel

// *** hw/cnts_regs.vh ***
// Register offsets, field positions and status codes of the transmit scheduler
`ifndef CNTS_REGS_VH
`define CNTS_REGS_VH

// ==========================================================
// Bus map (byte addresses, one word per register)
`define CNTS_OFF_BUF0 8'h00
`define CNTS_BUF_LAST 4'hE
`define CNTS_OFF_IEN 8'h40
`define CNTS_OFF_PEND 8'h44
`define CNTS_OFF_CLR 8'h48
`define CNTS_OFF_DIAG 8'h4C
`define CNTS_OFF_SCHED 8'h50

// ==========================================================
// Buffer control word fields
`define CNTS_ST_LSB 0
`define CNTS_RANK_LSB 4

// ==========================================================
// Status codes, bit 0 is the busy bit
`define CNTS_ST_RX_OFF 4'h0
`define CNTS_ST_RX_ARMED 4'h2
`define CNTS_ST_RX_HOLD 4'h4
`define CNTS_ST_RX_LOST 4'h6
`define CNTS_ST_TX_IDLE 4'h8
`define CNTS_ST_AWAIT 4'hA
`define CNTS_ST_SINGLE 4'hC
`define CNTS_ST_SEND_AWAIT 4'hE

// ==========================================================
// Reset values and widths
`define CNTS_NBUF 15
`define CNTS_ERR_W 8
`define CNTS_RST_ST 4'h0
`define CNTS_RST_RANK 4'h0
`define CNTS_ERR_BIT 15

`endif

// *** hw/cnts_tx_sched.v ***
// Transmit scheduler, buffer status machines and interrupt sources
//
// The placing of the registers and the APB register port were left to the implementer.
`include "cnts_regs.vh"

module cnts_tx_sched #(
    parameter NB = `CNTS_NBUF,
    parameter ERR_W = `CNTS_ERR_W,
    parameter [3:0] ST_TX_IDLE = `CNTS_ST_TX_IDLE,
    parameter [3:0] ST_SINGLE = `CNTS_ST_SINGLE
) (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    input wire crc_start,
    input wire frame_start,
    input wire tx_done,
    input wire tx_remote_frame,
    input wire tx_fail,
    input wire bus_resume,
    input wire rx_remote_hit,
    input wire rx_data_store,
    input wire [3:0] rx_buf_idx,
    input wire bus_error,
    input wire [ERR_W-1:0] error_cause,
    output reg tx_req_ff,
    output reg [3:0] tx_buf_idx_ff,
    output wire can_irq,
    output reg wakeup_evt_ff
);
    // ==========================================================
    // Phases of the link
    localparam [3:0] PH_IDLE = 4'h1;
    localparam [3:0] PH_FRAME = 4'h2;
    localparam [3:0] PH_CRC = 4'h4;
    localparam [3:0] PH_WAIT = 4'h8;

    reg [3:0] ph_ff, nxt_ph;
    reg cur_v_ff, nxt_cur_v;
    reg [3:0] cur_idx_ff, nxt_cur_idx;
    reg nxt_tx_req;
    reg [3:0] nxt_tx_buf_idx;
    reg sel_go, rev_sched, rev_cur;
    reg [ERR_W-1:0] diag_ff;
    reg [31:0] nxt_rdata;
    reg nxt_err;

    wire [4*NB-1:0] stat_w;
    wire [4*NB-1:0] rank_w;
    wire [NB-1:0] cand;
    wire [NB-1:0] cncl;
    wire [NB-1:0] bevt;
    wire [NB-1:0] sevt;
    wire found;
    wire [3:0] best_idx;
    wire [7:0] best_rank;
    wire [15:0] ien;
    wire [15:0] pend;

    // ==========================================================
    // Bus decode
    wire acc = psel & penable;
    wire bus_wr = acc & pwrite & pready_ff;
    wire aligned = (paddr[1:0] == 2'b00);
    wire buf_sel = aligned & (paddr[7:6] == 2'b00) & (paddr[5:2] <= `CNTS_BUF_LAST);
    wire [3:0] widx = paddr[5:2];
    wire hit_ien = (paddr == `CNTS_OFF_IEN);
    wire hit_pend = (paddr == `CNTS_OFF_PEND);
    wire hit_clr = (paddr == `CNTS_OFF_CLR);
    wire hit_diag = (paddr == `CNTS_OFF_DIAG);
    wire hit_sched = (paddr == `CNTS_OFF_SCHED);
    wire mapped = buf_sel | hit_ien | hit_pend | hit_clr | hit_diag | hit_sched;
    wire [7:0] sched_rank = {rank_w[4*tx_buf_idx_ff+:4], tx_buf_idx_ff};
    wire cancel = |cncl;

    // ==========================================================
    // Per-buffer status machine
    genvar g;
    generate
        for (g = 0; g < NB; g = g + 1) begin : g_buf
            localparam [3:0] GI = g;
            reg [3:0] st_ff, nxt_st;
            reg [3:0] rk_ff, nxt_rk;
            reg ev;
            wire wr_hit = bus_wr & buf_sel & (widx == GI);
            wire is_sched = tx_req_ff & (tx_buf_idx_ff == GI);
            wire busy_set = sel_go & (best_idx == GI);
            wire busy_clr = (rev_sched & is_sched) | (rev_cur & (cur_idx_ff == GI));
            wire done_hit = tx_done & cur_v_ff & (cur_idx_ff == GI) & (ph_ff == PH_CRC);
            wire rx_hit = rx_buf_idx == GI;
            wire tx_busy = st_ff[3] & st_ff[0];

            assign stat_w[4*g+:4] = st_ff;
            assign rank_w[4*g+:4] = rk_ff;
            assign cand[g] = (st_ff == ST_SINGLE) | (st_ff == `CNTS_ST_SEND_AWAIT);
            // Writing a different status code to the scheduled buffer withdraws it before its frame
            assign cncl[g] = wr_hit & is_sched & (pwdata[3:1] != st_ff[3:1]);
            assign bevt[g] = ev;
            assign sevt[g] = rx_data_store & rx_hit
                & ((st_ff == `CNTS_ST_RX_ARMED) | (st_ff == `CNTS_ST_RX_HOLD));

            always @* begin
                nxt_st = st_ff;
                nxt_rk = rk_ff;
                ev = 1'b0;
                if (wr_hit) begin
                    nxt_st = {pwdata[3:1], st_ff[0]};
                    if (cncl[g]) begin
                        nxt_st[0] = 1'b0;
                    end
                    if (!tx_busy) begin
                        nxt_rk = pwdata[`CNTS_RANK_LSB+:4];
                    end
                end
                if (rx_data_store & rx_hit) begin
                    if (st_ff == `CNTS_ST_RX_ARMED) begin
                        nxt_st = `CNTS_ST_RX_HOLD;
                        ev = 1'b1;
                    end else if (st_ff == `CNTS_ST_RX_HOLD) begin
                        nxt_st = `CNTS_ST_RX_LOST;
                        ev = 1'b1;
                    end
                end
                if (rx_remote_hit & rx_hit & (st_ff == `CNTS_ST_AWAIT)) begin
                    nxt_st = `CNTS_ST_SEND_AWAIT;
                    ev = 1'b1;
                end
                if (busy_set) begin
                    nxt_st[0] = 1'b1;
                end
                if (busy_clr) begin
                    nxt_st[0] = 1'b0;
                end
                if (done_hit & tx_busy) begin
                    ev = 1'b1;
                    if ({st_ff[3:1], 1'b0} == `CNTS_ST_SEND_AWAIT) begin
                        nxt_st = `CNTS_ST_AWAIT;
                    end else if (tx_remote_frame) begin
                        nxt_st = `CNTS_ST_RX_ARMED;
                    end else begin
                        nxt_st = ST_TX_IDLE;
                    end
                end
            end

            always @(posedge clk) begin
                if (reset) begin
                    st_ff <= `CNTS_RST_ST;
                    rk_ff <= `CNTS_RST_RANK;
                end else begin
                    st_ff <= nxt_st;
                    rk_ff <= nxt_rk;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Priority search
    cnts_rank_sel #(
        .NB(NB)
    ) u_sel (
        .cand(cand),
        .rank(rank_w),
        .found(found),
        .idx(best_idx),
        .best(best_rank)
    );

    // ==========================================================
    // Link phase and schedule slot
    always @* begin
        nxt_ph = ph_ff;
        nxt_cur_v = cur_v_ff;
        nxt_cur_idx = cur_idx_ff;
        nxt_tx_req = tx_req_ff & ~cancel;
        nxt_tx_buf_idx = tx_buf_idx_ff;
        sel_go = 1'b0;
        rev_sched = 1'b0;
        rev_cur = 1'b0;
        case (ph_ff)
            PH_IDLE: begin
                if (frame_start & tx_req_ff & ~cancel) begin
                    nxt_cur_v = 1'b1;
                    nxt_cur_idx = tx_buf_idx_ff;
                    nxt_tx_req = 1'b0;
                    nxt_ph = PH_FRAME;
                end
            end
            PH_FRAME: begin
                if (crc_start) begin
                    nxt_ph = PH_CRC;
                end
            end
            PH_CRC: begin
                if (tx_done) begin
                    nxt_cur_v = 1'b0;
                    nxt_ph = PH_IDLE;
                end
            end
            PH_WAIT: begin
                if (bus_resume) begin
                    nxt_ph = PH_IDLE;
                end
            end
            default: begin
                nxt_ph = PH_IDLE;
            end
        endcase
        if (tx_fail & (ph_ff == PH_FRAME | ph_ff == PH_CRC)) begin
            // Stop and return both to pending
            rev_cur = cur_v_ff;
            rev_sched = tx_req_ff;
            nxt_cur_v = 1'b0;
            nxt_tx_req = 1'b0;
            nxt_ph = PH_WAIT;
        end else if ((ph_ff == PH_CRC | (ph_ff == PH_IDLE & ~nxt_cur_v)) & found) begin
            if (~nxt_tx_req | (best_rank < sched_rank)) begin
                sel_go = 1'b1;
                rev_sched = nxt_tx_req;
                nxt_tx_req = 1'b1;
                nxt_tx_buf_idx = best_idx;
            end
        end
    end

    // ==========================================================
    // Read data and error answer
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err = ~mapped;
        if (buf_sel) begin
            nxt_rdata[7:0] = {rank_w[4*widx+:4], stat_w[4*widx+:4]};
        end else if (hit_ien) begin
            nxt_rdata[15:0] = ien;
        end else if (hit_pend) begin
            nxt_rdata[15:0] = pend;
        end else if (hit_diag) begin
            nxt_rdata[ERR_W-1:0] = diag_ff;
        end else if (hit_sched) begin
            nxt_rdata[11:0] = {ph_ff, cur_v_ff, cur_idx_ff[2:0], tx_req_ff, tx_buf_idx_ff[2:0]};
            nxt_rdata[15:12] = {cur_idx_ff[3], tx_buf_idx_ff[3], 2'b00};
        end
    end

    // ==========================================================
    // Interrupt sources
    cnts_irq_ctrl u_irq (
        .clk(clk),
        .reset(reset),
        .evt({bus_error, bevt}),
        .en_we(bus_wr & hit_ien),
        .clr_we(bus_wr & hit_clr),
        .wdata(pwdata[15:0]),
        .en_ff(ien),
        .pend_ff(pend),
        .irq_ff(can_irq)
    );

    // ==========================================================
    // Clocked state
    always @(posedge clk) begin
        if (reset) begin
            ph_ff <= PH_IDLE;
            cur_v_ff <= 1'b0;
            cur_idx_ff <= 4'h0;
            tx_req_ff <= 1'b0;
            tx_buf_idx_ff <= 4'h0;
            diag_ff <= {ERR_W{1'b0}};
            wakeup_evt_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ph_ff <= nxt_ph;
            cur_v_ff <= nxt_cur_v;
            cur_idx_ff <= nxt_cur_idx;
            tx_req_ff <= nxt_tx_req;
            tx_buf_idx_ff <= nxt_tx_buf_idx;
            diag_ff <= (diag_ff & ~((bus_wr & hit_diag) ? pwdata[ERR_W-1:0] : {ERR_W{1'b0}}))
                | (bus_error ? error_cause : {ERR_W{1'b0}});
            wakeup_evt_ff <= |sevt;
            // One wait state keeps read data registered
            pready_ff <= acc & ~pready_ff;
            pslverr_ff <= acc & ~pready_ff & nxt_err;
            if (acc & ~pready_ff) begin
                prdata_ff <= nxt_rdata;
            end
        end
    end
endmodule // cnts_tx_sched

// *** tb/cnts_bus_model.sv ***
// Behavioural CAN engine and remote nodes facing the scheduler
module cnts_bus_model (
    input wire logic clk,
    input wire logic tx_req_ff,
    output logic crc_start,
    output logic frame_start,
    output logic tx_done,
    output logic tx_remote_frame,
    output logic tx_fail,
    output logic bus_resume,
    output logic rx_remote_hit,
    output logic rx_data_store,
    output logic [3:0] rx_buf_idx,
    output logic bus_error,
    output logic [7:0] error_cause
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {crc_start, frame_start, tx_done, tx_remote_frame} = 4'h0;
        {tx_fail, bus_resume, rx_remote_hit, rx_data_store, bus_error} = 5'h00;
        rx_buf_idx = 4'hF;
        error_cause = 8'hFF;
    end
    // ==========================================================
    // start at once on request, CRC field later
    task automatic start_frame(output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        while (tx_req_ff !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        ok = tx_req_ff;
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        repeat (3) @(posedge clk);
        crc_start <= 1'b1;
        @(posedge clk);
        crc_start <= 1'b0;
    endtask
    // frame kind rides with done; inverted after so a stale level is not trusted
    task automatic finish_frame(input logic remote);
        @(posedge clk);
        tx_done <= 1'b1;
        tx_remote_frame <= remote;
        @(posedge clk);
        tx_done <= 1'b0;
        tx_remote_frame <= ~remote;
    endtask
    task automatic fail_frame;
        @(posedge clk);
        tx_fail <= 1'b1;
        @(posedge clk);
        tx_fail <= 1'b0;
    endtask
    task automatic resume;
        @(posedge clk);
        bus_resume <= 1'b1;
        @(posedge clk);
        bus_resume <= 1'b0;
    endtask
    // remote or data frame from another node
    task automatic rx_event(input logic remote, input logic [3:0] idx);
        @(posedge clk);
        rx_buf_idx <= idx;
        rx_remote_hit <= remote;
        rx_data_store <= ~remote;
        @(posedge clk);
        {rx_remote_hit, rx_data_store} <= 2'b00;
        rx_buf_idx <= ~idx;
    endtask
    task automatic err(input logic [7:0] cause);
        @(posedge clk);
        bus_error <= 1'b1;
        error_cause <= cause;
        @(posedge clk);
        bus_error <= 1'b0;
        error_cause <= ~cause;
    endtask
endmodule // cnts_bus_model

// *** tb/cnts_tx_sched_sva.sv ***
// Port assertions for the transmit scheduler
module cnts_sched_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready_ff,
    input wire logic pslverr_ff,
    input wire logic frame_start,
    input wire logic tx_done,
    input wire logic tx_fail,
    input wire logic rx_data_store,
    input wire logic rx_remote_hit,
    input wire logic bus_error,
    input wire logic tx_req_ff,
    input wire logic [3:0] tx_buf_idx_ff,
    input wire logic can_irq,
    input wire logic wakeup_evt_ff
);
    // ==========================================================
    // Anything that may raise the request line, enable writes too
    logic evt_any;
    assign evt_any = tx_done | rx_data_store | rx_remote_hit | bus_error | pready_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_APB_WAIT: assert property (psel && !penable ##1 psel && penable |=> pready_ff)
        else $error("ready missing after one wait state");
    AST_APB_PULSE: assert property (pready_ff |=> !pready_ff)
        else $error("ready longer than one cycle");
    AST_APB_ERR: assert property (pslverr_ff |-> pready_ff)
        else $error("error without ready");
    AST_IDX_RANGE: assert property (tx_req_ff |-> tx_buf_idx_ff <= 4'hE)
        else $error("scheduled index out of range");
    AST_START_CLR: assert property (frame_start && tx_req_ff |=> !tx_req_ff)
        else $error("request kept after frame start");
    AST_BACK2BACK: assert property (tx_done && tx_req_ff |=> tx_req_ff)
        else $error("next request lost at frame end");
    AST_FAIL_DROP: assert property (tx_fail |=> !tx_req_ff)
        else $error("request kept after failure");
    AST_REQ_FALL: assert property ($fell(tx_req_ff) |-> $past(frame_start) || $past(tx_fail)
        || $past(pready_ff) || $past(pready_ff, 2))
        else $error("request dropped without cause");
    AST_IRQ_CAUSE: assert property ($rose(can_irq) |-> $past(evt_any) || $past(evt_any, 2)
        || $past(evt_any, 3))
        else $error("interrupt without event");
    AST_WAKE: assert property (wakeup_evt_ff |-> $past(rx_data_store) ##1 !wakeup_evt_ff)
        else $error("wake-up not tied to a stored frame");
endmodule // cnts_sched_chk

bind cnts_tx_sched cnts_sched_chk u_chk (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .frame_start(frame_start), .tx_done(tx_done), .tx_fail(tx_fail),
    .rx_data_store(rx_data_store), .rx_remote_hit(rx_remote_hit), .bus_error(bus_error),
    .tx_req_ff(tx_req_ff), .tx_buf_idx_ff(tx_buf_idx_ff), .can_irq(can_irq),
    .wakeup_evt_ff(wakeup_evt_ff));

// *** tb/test_can_tx_buffer_scheduler.sv ***
// Self-checking bench for the transmit scheduler
module test_can_tx_buffer_scheduler;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, psel, penable, pwrite;
    logic [7:0] paddr, error_cause;
    logic [31:0] pwdata, prdata_ff, rd;
    logic pready_ff, pslverr_ff, err_seen, ok, crc_start, frame_start, tx_done;
    logic tx_remote_frame, tx_fail, bus_resume, rx_remote_hit, rx_data_store, bus_error;
    logic tx_req_ff, can_irq, wakeup_evt_ff;
    logic [3:0] rx_buf_idx, tx_buf_idx_ff;
    int miscompares = 0, num_checks = 0, cycles = 0;
    always #5 clk = ~clk;
    cnts_tx_sched dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
        .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .crc_start(crc_start),
        .frame_start(frame_start), .tx_done(tx_done), .tx_remote_frame(tx_remote_frame),
        .tx_fail(tx_fail), .bus_resume(bus_resume), .rx_remote_hit(rx_remote_hit),
        .rx_data_store(rx_data_store), .rx_buf_idx(rx_buf_idx), .bus_error(bus_error),
        .error_cause(error_cause), .tx_req_ff(tx_req_ff), .tx_buf_idx_ff(tx_buf_idx_ff),
        .can_irq(can_irq), .wakeup_evt_ff(wakeup_evt_ff));
    cnts_bus_model bm (.clk(clk), .tx_req_ff(tx_req_ff), .crc_start(crc_start),
        .frame_start(frame_start), .tx_done(tx_done), .tx_remote_frame(tx_remote_frame),
        .tx_fail(tx_fail), .bus_resume(bus_resume), .rx_remote_hit(rx_remote_hit),
        .rx_data_store(rx_data_store), .rx_buf_idx(rx_buf_idx), .bus_error(bus_error),
        .error_cause(error_cause));
    // ==========================================================
    // Shared tasks
    task automatic tally_and_finish;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Starts one edge late so two transfers never drive psel twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready_ff !== 1'b1 && n < 20);
        if (pready_ff !== 1'b1) miscompares++;
        rd = prdata_ff;
        err_seen = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    // Outputs are looked at mid-cycle, after the register update landed
    task automatic look;
        repeat (2) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        {psel, penable, pwrite} <= 3'b000;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rdchk(8'h14, 32'h0);
        rdchk(8'h40, 32'h0);
        apb(1'b0, 8'h54, 32'h0);
        check({rd[30:0], err_seen}, 32'h1);
        wr(8'h40, 32'hFFFF);
        wr(8'h24, 32'h1C);
        look;
        check({tx_req_ff, tx_buf_idx_ff}, 32'h19);
        wr(8'h08, 32'h1C);
        look;
        check({tx_req_ff, tx_buf_idx_ff}, 32'h12);
        wr(8'h14, 32'h0C);
        look;
        check({tx_req_ff, tx_buf_idx_ff}, 32'h15);
        rdchk(8'h08, 32'h1C);
        wr(8'h14, 32'hFD);
        rdchk(8'h14, 32'h0D);
        bm.start_frame(ok);
        look;
        check({ok, tx_req_ff, tx_buf_idx_ff}, 32'h32);
        rdchk(8'h50, 32'h4DA);
        bm.finish_frame(1'b0);
        look;
        check({can_irq, tx_req_ff, tx_buf_idx_ff}, 32'h32);
        rdchk(8'h14, 32'h08);
        bm.start_frame(ok);
        bm.finish_frame(1'b1);
        rdchk(8'h08, 32'h12);
        bm.start_frame(ok);
        bm.finish_frame(1'b0);
        rdchk(8'h24, 32'h18);
        rdchk(8'h44, 32'h224);
        wr(8'h48, 32'h20);
        wr(8'h44, 32'h0);
        rdchk(8'h44, 32'h204);
        wr(8'h40, 32'h0);
        look;
        check(can_irq, 32'h0);
        wr(8'h48, 32'hFFFF);
        wr(8'h40, 32'hFFFF);
        wr(8'h04, 32'h0E);
        bm.start_frame(ok);
        rdchk(8'h04, 32'h0F);
        bm.finish_frame(1'b0);
        rdchk(8'h04, 32'h0A);
        wr(8'h10, 32'h0A);
        look;
        check(tx_req_ff, 32'h0);
        bm.rx_event(1'b1, 4'h4);
        look;
        check({tx_req_ff, tx_buf_idx_ff}, 32'h14);
        rdchk(8'h44, 32'h12);
        bm.start_frame(ok);
        bm.finish_frame(1'b0);
        rdchk(8'h10, 32'h0A);
        wr(8'h18, 32'h08);
        rdchk(8'h18, 32'h08);
        wr(8'h18, 32'h0C);
        bm.start_frame(ok);
        bm.fail_frame;
        look;
        check(tx_req_ff, 32'h0);
        rdchk(8'h18, 32'h0C);
        bm.resume;
        look;
        check({tx_req_ff, tx_buf_idx_ff}, 32'h16);
        bm.start_frame(ok);
        bm.finish_frame(1'b0);
        wr(8'h1C, 32'h02);
        bm.rx_event(1'b0, 4'h7);
        @(negedge clk);
        check(wakeup_evt_ff, 32'h1);
        rdchk(8'h1C, 32'h04);
        bm.rx_event(1'b0, 4'h7);
        rdchk(8'h1C, 32'h06);
        bm.err(8'hA5);
        rdchk(8'h4C, 32'hA5);
        rdchk(8'h44, 32'h80D2);
        wr(8'h4C, 32'hA5);
        rdchk(8'h4C, 32'h0);
        tally_and_finish;
    end
endmodule // test_can_tx_buffer_scheduler
